/* File: fbci_host.sv */
// Behaviour
// - Writes drive select low, gate high, strobe low, with host data on lines.
// - Program, erase and protect need the full command sequence.
// - Commands open with AA to 5555 then 55 to 2AAA; code to 5555.
// - Erases take six writes ending 10 to 5555 or 30 to sector.
// - Suspend, resume D0 and clear-status 50 take three writes.
// - Read-status 70; the next read returns status.
// - Protect 60 then 20 or 40 to sector; verify 90; abort E0.
`timescale 1ns/10ps
`default_nettype none
module fbci_host (
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Flash pins.
   output logic [19:0]      flashAddr,
   output logic             chipSelN,
   output logic             outGateN,
   output logic             writeStrobeN,
   output logic             wordModeSel,
   output logic             idHighVoltage,
   input  wire logic [15:0] dataIn,
   output logic [15:0]      dataOut,
   output logic [15:0]      dataOe
);
   typedef enum {ST_IDLE, ST_WSETUP, ST_WLOW, ST_WHIGH, ST_RLOW, ST_RDONE} fbci_state_e;
   fbci_state_e stateQ;
   logic [31:0] ctrlQ;
   logic [19:0] addrQ;
   logic [15:0] wdataQ;
   logic [15:0] rdataQ;
   logic        doneQ;
   logic [2:0]  stepQ;
   logic [7:0]  cntQ;
   logic [3:0]  opQ;
   logic [2:0]  lastStep;
   logic [19:0] stepAddr;
   logic [15:0] stepData;
   logic        busy;
   logic        apbWr;
   logic        sectOk;
   // ------------------------------------------------------------
   // Register access.
   // ------------------------------------------------------------
   assign busy  = (stateQ != ST_IDLE);
   assign apbWr = psel && penable && pwrite;
   // Protect and unprotect only for the outer sectors.
   assign sectOk = (addrQ[19:15] == fbci_pkg::SECT_LOW) || (addrQ[19:15] == fbci_pkg::SECT_HIGH);
   // Control, address and write-data registers.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlQ  <= fbci_pkg::CTRL_RESET;
         addrQ  <= 20'h00000;
         wdataQ <= 16'h0000;
      end else if (apbWr && !busy) begin
         case (paddr)
            fbci_pkg::REG_CTRL:  ctrlQ  <= pwdata;
            fbci_pkg::REG_ADDR:  addrQ  <= pwdata[19:0];
            fbci_pkg::REG_WDATA: wdataQ <= pwdata[15:0];
            default:             ctrlQ  <= {ctrlQ[31:1], 1'b0};
         endcase
      end else begin
         ctrlQ[fbci_pkg::CTRL_GO_BIT] <= 1'b0;
      end
   end
   // Single-cycle APB answer with registered read data.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && (paddr > fbci_pkg::REG_STATUS || paddr[1:0] != 2'b00);
         case (paddr)
            fbci_pkg::REG_CTRL:   prdata <= ctrlQ;
            fbci_pkg::REG_ADDR:   prdata <= {12'h000, addrQ};
            fbci_pkg::REG_WDATA:  prdata <= {16'h0000, wdataQ};
            fbci_pkg::REG_RDATA:  prdata <= {16'h0000, rdataQ};
            fbci_pkg::REG_STATUS: prdata <= {30'h0, doneQ, busy};
            default:              prdata <= 32'h0000_0000;
         endcase
      end
   end
   // ------------------------------------------------------------
   // Sequence table.
   // ------------------------------------------------------------
   fbci_seq_rom uRom (
      .op       (opQ),
      .step     (stepQ),
      .userAddr (addrQ),
      .userData (wdataQ),
      .lastStep (lastStep),
      .stepAddr (stepAddr),
      .stepData (stepData)
   );
   // ------------------------------------------------------------
   // Bus cycle engine.
   // ------------------------------------------------------------
   // Walks reads and command writes on the flash pins.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stateQ        <= ST_IDLE;
         stepQ         <= 3'd0;
         cntQ          <= 8'h00;
         opQ           <= fbci_pkg::OP_READ;
         doneQ         <= 1'b0;
         rdataQ        <= 16'h0000;
         flashAddr     <= 20'h00000;
         chipSelN      <= 1'b1;
         outGateN      <= 1'b1;
         writeStrobeN  <= 1'b1;
         dataOut       <= 16'h0000;
         dataOe        <= 16'h0000;
         wordModeSel   <= 1'b1;
         idHighVoltage <= 1'b0;
      end else begin
         wordModeSel <= ctrlQ[fbci_pkg::CTRL_WORD_BIT];
         case (stateQ)
            ST_IDLE: begin
               chipSelN     <= 1'b1;
               outGateN     <= 1'b1;
               writeStrobeN <= 1'b1;
               dataOe       <= 16'h0000;
               if (ctrlQ[fbci_pkg::CTRL_GO_BIT]) begin
                  opQ   <= ctrlQ[fbci_pkg::CTRL_OP_LSB +: 4];
                  stepQ <= 3'd0;
                  doneQ <= 1'b0;
                  cntQ  <= 8'h00;
                  idHighVoltage <= ctrlQ[fbci_pkg::CTRL_IDHV_BIT];
                  if (ctrlQ[fbci_pkg::CTRL_OP_LSB +: 4] == fbci_pkg::OP_READ) begin
                     flashAddr <= addrQ;
                     stateQ    <= ST_RLOW;
                  end else if ((ctrlQ[fbci_pkg::CTRL_OP_LSB +: 4] == fbci_pkg::OP_PROTECT ||
                                ctrlQ[fbci_pkg::CTRL_OP_LSB +: 4] == fbci_pkg::OP_UNPROTECT) && !sectOk) begin
                     doneQ <= 1'b1;
                  end else begin
                     stateQ <= ST_WSETUP;
                  end
               end
            end
            // Address is set up before the strobe falls.
            ST_WSETUP: begin
               if (opQ == fbci_pkg::OP_WRITE) begin
                  flashAddr <= addrQ;
                  dataOut   <= wdataQ;
               end else begin
                  flashAddr <= stepAddr;
                  dataOut   <= stepData;
               end
               dataOe   <= ctrlQ[fbci_pkg::CTRL_WORD_BIT] ? 16'hFFFF : 16'h00FF;
               chipSelN <= 1'b0;
               outGateN <= 1'b1;
               cntQ     <= 8'h00;
               stateQ   <= ST_WLOW;
            end
            // Strobe low; address taken on its fall, data on its rise.
            ST_WLOW: begin
               writeStrobeN <= 1'b0;
               cntQ <= cntQ + 8'h01;
               if (cntQ == 8'(fbci_pkg::LOW_CYC)) begin
                  writeStrobeN <= 1'b1;
                  cntQ   <= 8'h00;
                  stateQ <= ST_WHIGH;
               end
            end
            ST_WHIGH: begin
               cntQ <= cntQ + 8'h01;
               if (cntQ == 8'(fbci_pkg::HIGH_CYC)) begin
                  chipSelN <= 1'b1;
                  dataOe   <= 16'h0000;
                  if (opQ == fbci_pkg::OP_WRITE || stepQ == lastStep) begin
                     doneQ  <= 1'b1;
                     stateQ <= ST_IDLE;
                  end else begin
                     stepQ  <= stepQ + 3'd1;
                     stateQ <= ST_WSETUP;
                  end
               end
            end
            // Read: select and gate low, strobe high.
            ST_RLOW: begin
               chipSelN <= 1'b0;
               outGateN <= 1'b0;
               cntQ <= cntQ + 8'h01;
               if (cntQ == 8'(fbci_pkg::READ_CYC)) begin
                  rdataQ <= ctrlQ[fbci_pkg::CTRL_WORD_BIT] ? dataIn : {8'h00, dataIn[7:0]};
                  stateQ <= ST_RDONE;
               end
            end
            ST_RDONE: begin
               chipSelN      <= 1'b1;
               outGateN      <= 1'b1;
               idHighVoltage <= 1'b0;
               doneQ         <= 1'b1;
               stateQ        <= ST_IDLE;
            end
            default: stateQ <= ST_IDLE;
         endcase
      end
   end
endmodule // fbci_host
`default_nettype wire

/* File: fbci_pkg.sv */
`default_nettype none
package fbci_pkg;
   // ------------------------------------------------------------
   // APB register map of the controller.
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_RDATA  = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   // CTRL fields.
   localparam int CTRL_GO_BIT    = 0;
   localparam int CTRL_OP_LSB    = 4;
   localparam int CTRL_WORD_BIT  = 8;
   localparam int CTRL_IDHV_BIT  = 9;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
   // STATUS fields.
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_DONE_BIT  = 1;
   // ------------------------------------------------------------
   // Operation codes written to CTRL.OP.
   // ------------------------------------------------------------
   localparam logic [3:0] OP_READ       = 4'h0;
   localparam logic [3:0] OP_WRITE      = 4'h1;
   localparam logic [3:0] OP_RESET      = 4'h2;
   localparam logic [3:0] OP_ID         = 4'h3;
   localparam logic [3:0] OP_PROGRAM    = 4'h4;
   localparam logic [3:0] OP_CHIP_ERASE = 4'h5;
   localparam logic [3:0] OP_SECT_ERASE = 4'h6;
   localparam logic [3:0] OP_SUSPEND    = 4'h7;
   localparam logic [3:0] OP_RESUME     = 4'h8;
   localparam logic [3:0] OP_RD_STATUS  = 4'h9;
   localparam logic [3:0] OP_CLR_STATUS = 4'hA;
   localparam logic [3:0] OP_PROTECT    = 4'hB;
   localparam logic [3:0] OP_UNPROTECT  = 4'hC;
   localparam logic [3:0] OP_ABORT      = 4'hD;
   // ------------------------------------------------------------
   // Command sequence addresses and codes.
   // ------------------------------------------------------------
   localparam logic [14:0] UNLOCK_ADDR1 = 15'h5555;
   localparam logic [14:0] UNLOCK_ADDR2 = 15'h2AAA;
   localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
   localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0]  CMD_RESET    = 8'hF0;
   localparam logic [7:0]  CMD_ID       = 8'h90;
   localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
   localparam logic [7:0]  CMD_ERASE    = 8'h80;
   localparam logic [7:0]  CMD_CHIP     = 8'h10;
   localparam logic [7:0]  CMD_SECTOR   = 8'h30;
   localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
   localparam logic [7:0]  CMD_RESUME   = 8'hD0;
   localparam logic [7:0]  CMD_RDSTAT   = 8'h70;
   localparam logic [7:0]  CMD_CLRSTAT  = 8'h50;
   localparam logic [7:0]  CMD_PROT_PRE = 8'h60;
   localparam logic [7:0]  CMD_PROTECT  = 8'h20;
   localparam logic [7:0]  CMD_UNPROT   = 8'h40;
   localparam logic [7:0]  CMD_ABORT    = 8'hE0;
   localparam logic [4:0]  SECT_LOW     = 5'b00000;
   localparam logic [4:0]  SECT_HIGH    = 5'b11111;
   // ------------------------------------------------------------
   // Bus timing: strobe low and high phases at 200 MHz.
   // ------------------------------------------------------------
   localparam int CLK_MHZ        = 200;
   localparam int STROBE_LOW_NS  = 50;
   localparam int STROBE_HIGH_NS = 30;
   localparam int READ_ACC_NS    = 120;
   localparam int LOW_CYC  = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_CYC = (READ_ACC_NS * CLK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

/* File: fbci_seq_rom.sv */
`timescale 1ns/10ps
`default_nettype none
// Gives the bus write for one step of a command sequence.
module fbci_seq_rom (
   // Selection.
   input  wire logic [3:0]  op,
   input  wire logic [2:0]  step,
   input  wire logic [19:0] userAddr,
   input  wire logic [15:0] userData,
   // Result.
   output logic [2:0]       lastStep,
   output logic [19:0]      stepAddr,
   output logic [15:0]      stepData
);
   logic [7:0] code3;
   logic [7:0] code6;
   logic       sixCycle;
   // ------------------------------------------------------------
   // Step table.
   // ------------------------------------------------------------
   // Third and sixth cycle codes per operation.
   always_comb begin
      code3    = fbci_pkg::CMD_RESET;
      code6    = fbci_pkg::CMD_CHIP;
      sixCycle = 1'b0;
      case (op)
         fbci_pkg::OP_ID:         code3 = fbci_pkg::CMD_ID;
         fbci_pkg::OP_PROGRAM:    code3 = fbci_pkg::CMD_PROGRAM;
         fbci_pkg::OP_CHIP_ERASE: begin
            code3 = fbci_pkg::CMD_ERASE;
            sixCycle = 1'b1;
         end
         fbci_pkg::OP_SECT_ERASE: begin
            code3 = fbci_pkg::CMD_ERASE;
            code6 = fbci_pkg::CMD_SECTOR;
            sixCycle = 1'b1;
         end
         fbci_pkg::OP_SUSPEND:    code3 = fbci_pkg::CMD_SUSPEND;
         fbci_pkg::OP_RESUME:     code3 = fbci_pkg::CMD_RESUME;
         fbci_pkg::OP_RD_STATUS:  code3 = fbci_pkg::CMD_RDSTAT;
         fbci_pkg::OP_CLR_STATUS: code3 = fbci_pkg::CMD_CLRSTAT;
         fbci_pkg::OP_PROTECT: begin
            code3 = fbci_pkg::CMD_PROT_PRE;
            code6 = fbci_pkg::CMD_PROTECT;
            sixCycle = 1'b1;
         end
         fbci_pkg::OP_UNPROTECT: begin
            code3 = fbci_pkg::CMD_PROT_PRE;
            code6 = fbci_pkg::CMD_UNPROT;
            sixCycle = 1'b1;
         end
         fbci_pkg::OP_ABORT:      code3 = fbci_pkg::CMD_ABORT;
         default:                 code3 = fbci_pkg::CMD_RESET;
      endcase
   end
   // Address and data of the current step; upper address bits zero for unlocks.
   always_comb begin
      lastStep = sixCycle ? 3'd5 : ((op == fbci_pkg::OP_PROGRAM) ? 3'd3 : 3'd2);
      stepData = {8'h00, fbci_pkg::UNLOCK_DATA1};
      stepAddr = {5'h00, fbci_pkg::UNLOCK_ADDR1};
      case (step)
         3'd0, 3'd3: begin
            stepData = {8'h00, fbci_pkg::UNLOCK_DATA1};
            stepAddr = {5'h00, fbci_pkg::UNLOCK_ADDR1};
            if (step == 3'd3 && op == fbci_pkg::OP_PROGRAM) begin
               stepData = userData;
               stepAddr = userAddr;
            end
         end
         3'd1, 3'd4: begin
            stepData = {8'h00, fbci_pkg::UNLOCK_DATA2};
            stepAddr = {5'h00, fbci_pkg::UNLOCK_ADDR2};
         end
         3'd2: begin
            stepData = {8'h00, code3};
            stepAddr = {5'h00, fbci_pkg::UNLOCK_ADDR1};
         end
         3'd5: begin
            stepData = {8'h00, code6};
            stepAddr = (op == fbci_pkg::OP_CHIP_ERASE) ? {5'h00, fbci_pkg::UNLOCK_ADDR1} : userAddr;
         end
         default: begin
            stepData = 16'h0000;
            stepAddr = 20'h00000;
         end
      endcase
   end
endmodule // fbci_seq_rom
`default_nettype wire

/* File: fbci_host_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// Watches the APB side and the flash strobes of the controller.
module fbci_host_chk (
   // Clock and reset.
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // APB.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // Flash pins.
   input wire logic [19:0] flashAddr,
   input wire logic        chipSelN,
   input wire logic        outGateN,
   input wire logic        writeStrobeN,
   input wire logic        wordModeSel,
   input wire logic [15:0] dataOut,
   input wire logic [15:0] dataOe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] lowCnt_q;
   // Counts the cycles that the write strobe has been low.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) lowCnt_q <= 8'h00;
      else if (writeStrobeN) lowCnt_q <= 8'h00;
      else lowCnt_q <= lowCnt_q + 8'h01;
   end
   pready_timing_a: assert property (psel && !penable |=> pready) else $error("pready late");
   pready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("pready without setup");
   slverr_map_a: assert property (pready && paddr > 8'h10 |-> pslverr) else $error("unmapped not refused");
   write_mode_a: assert property (!writeStrobeN |-> !chipSelN && outGateN) else $error("bad write");
   read_mode_a: assert property (!outGateN |-> !chipSelN && writeStrobeN) else $error("bad read");
   drive_gate_a: assert property ((wordModeSel ? |dataOe : |dataOe[14:0]) |-> outGateN)
      else $error("host drives while device may");
   byte_upper_a: assert property (!wordModeSel |-> dataOe[14:8] == 7'h00) else $error("upper lines driven");
   strobe_len_a: assert property ($rose(writeStrobeN) |-> lowCnt_q == 8'(fbci_pkg::LOW_CYC))
      else $error("strobe width wrong");
   strobe_hold_a: assert property (!writeStrobeN |-> $stable(flashAddr) && $stable(dataOut))
      else $error("address or data moved");
   cover property ($rose(writeStrobeN));
   cover property (pready && pslverr);
   cover property ($fell(outGateN) && !wordModeSel);
endmodule // fbci_host_chk
bind fbci_host fbci_host_chk i_fbci_host_chk (.ref_clk, .rst_n, .psel, .penable, .paddr, .pready, .pslverr,
   .flashAddr, .chipSelN, .outGateN, .writeStrobeN, .wordModeSel, .dataOut, .dataOe);
`default_nettype wire

/* File: fbci_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Behavioural flash device: command latch, small array, identifier and status reads.
module fbci_flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value.
   parameter logic [7:0] PART_CODE  = 8'h7E, // Arbitrary value.
   parameter logic [7:0] STAT_VAL   = 8'h80
) (
   // Flash pins.
   input wire logic [19:0] flashAddr,
   input wire logic        chipSelN,
   input wire logic        outGateN,
   input wire logic        writeStrobeN,
   input wire logic        wordModeSel,
   input wire logic        idHighVoltage,
   input wire logic [15:0] dataOut,
   input wire logic [15:0] dataOe,
   output logic [15:0]     dataIn
);
   logic [15:0] mem [0:255];
   logic [15:0] rdVal, lastRd;
   logic [19:0] programLocation;
   logic [7:0]  armCode, byteVal;
   logic [2:0]  step;
   logic [1:0]  readMode;
   logic        protLo, protHi, active;
   int          wrCount = 0;
   function automatic logic [7:0] ix(input logic [19:0] a);
      return {a[15], a[6:0]};
   endfunction
   // Powers up reading the array with a known pattern.
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = {i[7:0] ^ 8'hA5, i[7:0]};
      readMode = 2'd0;
      step = 3'd0;
      protLo = 1'b0;
      protHi = 1'b0;
      lastRd = 16'h0000;
   end
   // Address is taken as the strobe falls.
   always @(negedge writeStrobeN) programLocation = flashAddr;
   // Data is taken as the strobe rises and steps the command latch.
   always @(posedge writeStrobeN) begin : take
      logic [7:0] d;
      logic [14:0] a;
      logic hit;
      d = dataOut[7:0];
      a = programLocation[14:0];
      if (chipSelN === 1'b0) begin
         wrCount++;
         if (step == 3'd3 && armCode == 8'hA0) begin
            mem[ix(programLocation)] = dataOut;
            step = 3'd0;
            readMode = 2'd2;
         end else begin
            case (step)
               3'd0, 3'd3: hit = a === 15'h5555 && d === 8'hAA;
               3'd1, 3'd4: hit = a === 15'h2AAA && d === 8'h55;
               3'd2: hit = a === 15'h5555;
               default: hit = 1'b1;
            endcase
            if (!hit) step = 3'd0;
            else if (step == 3'd2) begin
               step = 3'd0;
               case (d)
                  8'hF0: readMode = 2'd0;
                  8'h90: readMode = 2'd1;
                  8'h70: readMode = 2'd2;
                  8'hA0, 8'h80, 8'h60: begin
                     armCode = d;
                     step = 3'd3;
                  end
                  default: ;
               endcase
            end else if (step == 3'd5) begin
               step = 3'd0;
               // The write engine finishes at this edge, so no command ever arrives while it runs.
               readMode = 2'd2;
               if (armCode == 8'h80 && d == 8'h10 && a == 15'h5555) begin
                  for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
               end else if (armCode == 8'h80 && d == 8'h30) begin
                  for (int i = 0; i < 256; i++) if (i[7] == programLocation[15]) mem[i] = 16'hFFFF;
               end else if (armCode == 8'h60 && (d == 8'h20 || d == 8'h40)) begin
                  if (programLocation[19:15] == 5'b00000) protLo = (d == 8'h20);
                  if (programLocation[19:15] == 5'b11111) protHi = (d == 8'h20);
               end
            end else step = step + 3'd1;
         end
      end
   end
   // Picks array, identifier or status data for a read.
   always_comb begin
      rdVal = mem[ix(flashAddr)];
      if (idHighVoltage || readMode == 2'd1) begin
         case (flashAddr[1:0])
            2'b00: rdVal = {8'h00, MAKER_CODE};
            2'b01: rdVal = {8'h00, PART_CODE};
            2'b11: rdVal = ((flashAddr[19:15] == 5'h00 && protLo) || (flashAddr[19:15] == 5'h1F && protHi)) ?
                           {8'h00, MAKER_CODE} : 16'h0000;
            default: rdVal = 16'h0000;
         endcase
      end else if (readMode == 2'd2) rdVal = {8'h00, STAT_VAL};
      byteVal = (dataOe[15] && dataOut[15]) ? rdVal[15:8] : rdVal[7:0];
   end
   assign active = !chipSelN && !outGateN && writeStrobeN;
   // Remembers the last driven word so a floating bus shows its inverse.
   always @* if (active) lastRd = rdVal;
   assign dataIn = active ? (wordModeSel ? rdVal : {~lastRd[15:8], byteVal}) : ~lastRd;
endmodule // fbci_flash_model
`default_nettype wire

/* File: tb_flash_bus_command_interface.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb_flash_bus_command_interface;
   localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value.
   localparam logic [7:0] PART  = 8'h7E; // Arbitrary value.
   localparam logic [7:0] STAT  = 8'h80;
   logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
   logic        chipSelN, outGateN, writeStrobeN, wordModeSel, idHighVoltage;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [19:0] flashAddr, a;
   logic [15:0] dataIn, dataOut, dataOe, d;
   logic [15:0] shadow [0:255];
   logic [3:0]  tw [4] = '{fbci_pkg::OP_SUSPEND, fbci_pkg::OP_RESUME, fbci_pkg::OP_CLR_STATUS, fbci_pkg::OP_ABORT};
   logic [19:0] wa [6] = '{20'hF5555, 20'hA2AAA, 20'h01234, 20'hF5555, 20'hA2AAA, 20'h35555};
   logic [15:0] wv [6] = '{16'hFFAA, 16'h0055, 16'h0070, 16'h12AA, 16'h3455, 16'hFF70};
   int          err_count = 0;
   int          compares = 0;
   int          base;
   fbci_host i_fbci_host (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .flashAddr, .chipSelN, .outGateN, .writeStrobeN, .wordModeSel, .idHighVoltage, .dataIn, .dataOut, .dataOe);
   fbci_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .STAT_VAL(STAT)) i_fbci_flash_model (.flashAddr,
      .chipSelN, .outGateN, .writeStrobeN, .wordModeSel, .idHighVoltage, .dataOut, .dataOe, .dataIn);
   // Clock of 5 ns period.
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   function automatic logic [7:0] ix(input logic [19:0] ad);
      return {ad[15], ad[6:0]};
   endfunction
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One APB transfer; result lands in r and e. It starts one edge after the call, so psel never flips twice in a step.
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         conclude();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Runs one controller operation and waits for it to finish.
   task automatic op(input logic [3:0] c, input logic [19:0] ad, input logic [15:0] wd, input logic wm, input logic hv);
      int n;
      n = 0;
      apb(1'b1, fbci_pkg::REG_ADDR, {12'h000, ad});
      apb(1'b1, fbci_pkg::REG_WDATA, {16'h0000, wd});
      apb(1'b1, fbci_pkg::REG_CTRL, {22'h0, hv, wm, c, 4'h1});
      repeat (2) @(posedge ref_clk);
      do begin
         apb(1'b0, fbci_pkg::REG_STATUS, 32'h0);
         n++;
      end while ((r[fbci_pkg::STAT_DONE_BIT] !== 1'b1 || r[fbci_pkg::STAT_BUSY_BIT] !== 1'b0) && n < 500);
      if (n >= 500) begin
         err_count++;
         conclude();
      end
   endtask
   task automatic rd(input logic [19:0] ad, input logic wm, input logic hv);
      op(fbci_pkg::OP_READ, ad, 16'h0000, wm, hv);
      apb(1'b0, fbci_pkg::REG_RDATA, 32'h0);
   endtask
   // Main sequence.
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      base = $urandom(32'hE985);
      for (int i = 0; i < 256; i++) shadow[i] = {i[7:0] ^ 8'hA5, i[7:0]};
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, fbci_pkg::REG_CTRL, 32'h0);
      `CHK("ctrl", fbci_pkg::CTRL_RESET, r)
      apb(1'b0, 8'h14, 32'h0);
      `CHK("unmapped", 1'b1, e)
      a = 20'h0003C;
      rd(a, 1'b1, 1'b0);
      `CHK("word read", shadow[ix(a)], r[15:0])
      rd(a, 1'b0, 1'b0);
      `CHK("byte read", shadow[ix(a)][7:0], r[7:0])
      rd(20'h00000, 1'b1, 1'b1);
      `CHK("maker", {8'h00, MAKER}, r[15:0])
      rd(20'h00001, 1'b0, 1'b1);
      `CHK("part", PART, r[7:0])
      op(fbci_pkg::OP_ID, 20'h0, 16'h0, 1'b1, 1'b0);
      rd(20'h00001, 1'b1, 1'b0);
      `CHK("id cmd", {8'h00, PART}, r[15:0])
      for (int k = 0; k < 5; k++) begin
         a = (k == 0) ? 20'hFFFFF : 20'($urandom());
         d = (k == 0) ? 16'h0000 : 16'($urandom());
         op(fbci_pkg::OP_PROGRAM, a, d, 1'b1, 1'b0);
         shadow[ix(a)] = d;
         op(fbci_pkg::OP_RESET, 20'h0, 16'h0, 1'b1, 1'b0);
         rd(a, 1'b1, 1'b0);
         `CHK("program", shadow[ix(a)], r[15:0])
      end
      op(fbci_pkg::OP_RD_STATUS, 20'h0, 16'h0, 1'b1, 1'b0);
      for (int k = 0; k < 2; k++) begin
         rd(20'($urandom()), 1'b1, 1'b0);
         `CHK("status", {8'h00, STAT}, r[15:0])
      end
      op(fbci_pkg::OP_RESET, 20'h0, 16'h0, 1'b1, 1'b0);
      for (int k = 0; k < 6; k++) begin
         op(fbci_pkg::OP_WRITE, wa[k], wv[k], 1'b1, 1'b0);
         if (k == 2 || k == 5) begin
            rd(a, 1'b1, 1'b0);
            `CHK("raw cmd", (k == 2) ? shadow[ix(a)] : {8'h00, STAT}, r[15:0])
         end
      end
      op(fbci_pkg::OP_RESET, 20'h0, 16'h0, 1'b1, 1'b0);
      base = i_fbci_flash_model.wrCount;
      op(fbci_pkg::OP_PROTECT, 20'h08000, 16'h0, 1'b1, 1'b0);
      `CHK("refused", base, i_fbci_flash_model.wrCount)
      op(fbci_pkg::OP_PROTECT, 20'hF8000, 16'h0, 1'b1, 1'b0);
      rd(20'hF8003, 1'b1, 1'b1);
      `CHK("protect", {8'h00, MAKER}, r[15:0])
      op(fbci_pkg::OP_UNPROTECT, 20'hF8000, 16'h0, 1'b1, 1'b0);
      rd(20'hF8003, 1'b1, 1'b1);
      `CHK("unprotect", 16'h0000, r[15:0])
      foreach (tw[k]) begin
         base = i_fbci_flash_model.wrCount;
         op(tw[k], 20'h0, 16'h0, 1'b1, 1'b0);
         `CHK("three writes", base + 3, i_fbci_flash_model.wrCount)
      end
      base = i_fbci_flash_model.wrCount;
      op(fbci_pkg::OP_SECT_ERASE, 20'h08000, 16'h0, 1'b1, 1'b0);
      `CHK("six writes", base + 6, i_fbci_flash_model.wrCount)
      for (int i = 128; i < 256; i++) shadow[i] = 16'hFFFF;
      op(fbci_pkg::OP_RESET, 20'h0, 16'h0, 1'b1, 1'b0);
      for (int k = 0; k < 2; k++) begin
         rd({4'h0, k[0], 15'h0011}, 1'b1, 1'b0);
         `CHK("sector erase", shadow[{k[0], 7'h11}], r[15:0])
      end
      op(fbci_pkg::OP_CHIP_ERASE, 20'h0, 16'h0, 1'b1, 1'b0);
      op(fbci_pkg::OP_RESET, 20'h0, 16'h0, 1'b1, 1'b0);
      rd(20'h00011, 1'b1, 1'b0);
      `CHK("chip erase", 16'hFFFF, r[15:0])
      conclude();
   end
endmodule // tb_flash_bus_command_interface
`default_nettype wire
